/* File: design/adcc_conv_ctrl.sv */
// control and sequencing of a 10-bit five-input successive approximation converter
// assumes an apb master on pclk, an analog front end outside the clock domain
//
// Contract
// - clear halving: codes 00,01,10 divide 2,8,32
// - set halving: same codes divide 4,16,64
// - code 11 uses internal rc clock
// - channel codes 000-100 pick inputs 0-4
// - writing go starts, reads one while converting
// - hardware clears go at conversion end
// - power bit off shuts converter down
// - unimplemented control bits read as zero
// - format bit picks right or left justification
// - completion loads result, clears go, sets flag
// - pin config decodes analog or digital pins
// - pin config also selects reference sources
// - conversion lasts nine bit periods
// - sampler disconnected two bit periods afterwards
// - clearing go aborts, result kept unchanged
// - compare trigger starts conversion only when on
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_conv_ctrl #(
	parameter logic [3:0] CONV_TADS = `ADCC_CONV_TADS,
	parameter logic [3:0] HOLDOFF_TADS = `ADCC_HOLDOFF_TADS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rc_clock_pin,
	input wire logic [9:0] cmp_code,
	input wire logic special_event_trigger,
	output logic converter_enable,
	output logic [2:0] mux_select,
	output logic [4:0] analog_pins,
	output logic vref_pos_ext,
	output logic vref_neg_ext,
	output logic sample_connect,
	output logic convert_active,
	output logic conversion_done_flag
);
	import adcc_pkg::*;

	adcc_state_t s;
	adcc_state_t next_s;
	logic wr_commit;
	logic rd_access;
	logic wr_a;
	logic wr_b;
	logic wr_hi;
	logic wr_lo;
	logic wr_st;
	logic go_req;
	logic abort_req;
	logic start_req;
	logic tad_tick;
	logic complete;
	logic [31:0] rd_word;
	logic rd_hit;

	adcc_tad_if tad_bus ();

	adcc_tad_gen u_tad_gen (
		.pclk(pclk),
		.presetn(presetn),
		.pclk_en(pclk_en),
		.bus(tad_bus.gen)
	);

	// true when the byte address selects the register with this index
	function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
		reg_hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
	endfunction : reg_hit

	// analog pin map {in4..in0}, reference pins count as analog
	function automatic logic [4:0] pin_map(input logic [3:0] cfg);
		case (cfg)
			4'h4: pin_map = 5'b01011;
			4'h5: pin_map = 5'b01011;
			4'h6: pin_map = 5'b00000;
			4'h7: pin_map = 5'b00000;
			4'hD: pin_map = 5'b01111;
			4'hE: pin_map = 5'b00001;
			4'hF: pin_map = 5'b01101;
			default: pin_map = 5'b11111;
		endcase
	endfunction : pin_map

	// positive reference from input three
	function automatic logic pos_ref(input logic [3:0] cfg);
		case (cfg)
			4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF: pos_ref = 1'b1;
			default: pos_ref = 1'b0;
		endcase
	endfunction : pos_ref

	// negative reference from input two
	function automatic logic neg_ref(input logic [3:0] cfg);
		case (cfg)
			4'h8, 4'hB, 4'hC, 4'hD, 4'hF: neg_ref = 1'b1;
			default: neg_ref = 1'b0;
		endcase
	endfunction : neg_ref

	// place the code in the 16-bit result pair
	function automatic logic [15:0] justify_code(input logic right, input logic [9:0] code);
		if (right) begin
			justify_code = {6'h00, code};
		end else begin
			justify_code = {code, 6'h00};
		end
	endfunction : justify_code

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign converter_enable = s.converter_enable;
	assign mux_select = s.mux_select;
	assign analog_pins = s.analog_pins;
	assign vref_pos_ext = s.vref_pos_ext;
	assign vref_neg_ext = s.vref_neg_ext;
	assign sample_connect = s.sample_connect;
	assign convert_active = s.convert_active;
	assign conversion_done_flag = s.done_flag;

	assign tad_bus.clk_select = s.clk_select;
	assign tad_bus.halving = s.halving;
	assign tad_bus.run = s.power_on;
	assign tad_bus.restart = s.tad_restart;
	assign tad_bus.rc_tick = s.rc_sync & ~s.rc_prev;

	// a tick already in flight when the divider restarts is stale
	assign tad_tick = tad_bus.tick & ~s.tad_restart;

	// read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		if (reg_hit(paddr, `ADCC_IDX_CONTROL_A)) begin
			rd_word[`ADCC_A_CLK_SEL_HI:`ADCC_A_CLK_SEL_LO] = s.clk_select;
			rd_word[`ADCC_A_CHAN_HI:`ADCC_A_CHAN_LO] = s.channel;
			rd_word[`ADCC_A_GO] = (s.phase == ADCC_CONVERT);
			rd_word[`ADCC_A_POWER] = s.power_on;
		end else if (reg_hit(paddr, `ADCC_IDX_CONTROL_B)) begin
			rd_word[`ADCC_B_JUSTIFY] = s.justify;
			rd_word[`ADCC_B_HALVING] = s.halving;
			rd_word[`ADCC_B_PCFG_HI:`ADCC_B_PCFG_LO] = s.pin_cfg;
		end else if (reg_hit(paddr, `ADCC_IDX_RESULT_HIGH)) begin
			rd_word[7:0] = s.result[15:8];
		end else if (reg_hit(paddr, `ADCC_IDX_RESULT_LOW)) begin
			rd_word[7:0] = s.result[7:0];
		end else if (reg_hit(paddr, `ADCC_IDX_STATUS)) begin
			rd_word[`ADCC_S_DONE] = s.done_flag;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// bus strobes, writes land at the edge that samples pready high
	always_comb begin
		rd_access = psel & penable & ~s.pready;
		wr_commit = psel & penable & s.pready & pwrite & ~s.pslverr;
		wr_a = wr_commit & reg_hit(paddr, `ADCC_IDX_CONTROL_A);
		wr_b = wr_commit & reg_hit(paddr, `ADCC_IDX_CONTROL_B);
		wr_hi = wr_commit & reg_hit(paddr, `ADCC_IDX_RESULT_HIGH);
		wr_lo = wr_commit & reg_hit(paddr, `ADCC_IDX_RESULT_LOW);
		wr_st = wr_commit & reg_hit(paddr, `ADCC_IDX_STATUS);
		go_req = wr_a & pwdata[`ADCC_A_GO] & pwdata[`ADCC_A_POWER] & s.power_on;
		abort_req = wr_a & ~pwdata[`ADCC_A_GO];
		start_req = go_req | (special_event_trigger & s.power_on);
		complete = (s.phase == ADCC_CONVERT) & tad_tick & (s.tad_count == CONV_TADS - 4'h1);
	end

	always_comb begin
		next_s = s;

		// two-stage synchronisers for signals from the analog side
		next_s.rc_meta = rc_clock_pin;
		next_s.rc_sync = s.rc_meta;
		next_s.rc_prev = s.rc_sync;
		next_s.cmp_meta = cmp_code;
		next_s.cmp_sync = s.cmp_meta;

		// apb: one wait state, answer registered
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (rd_access) begin
			next_s.pready = 1'b1;
			next_s.pslverr = ~rd_hit;
			next_s.prdata = rd_word;
		end

		// register writes: configuration, result bytes, done flag clear
		if (wr_a) begin
			next_s.clk_select = pwdata[`ADCC_A_CLK_SEL_HI:`ADCC_A_CLK_SEL_LO];
			next_s.channel = pwdata[`ADCC_A_CHAN_HI:`ADCC_A_CHAN_LO];
			next_s.power_on = pwdata[`ADCC_A_POWER];
		end
		if (wr_b) begin
			next_s.justify = pwdata[`ADCC_B_JUSTIFY];
			next_s.halving = pwdata[`ADCC_B_HALVING];
			next_s.pin_cfg = pwdata[`ADCC_B_PCFG_HI:`ADCC_B_PCFG_LO];
		end
		if (wr_hi) begin
			next_s.result[15:8] = pwdata[7:0];
		end
		if (wr_lo) begin
			next_s.result[7:0] = pwdata[7:0];
		end
		if (wr_st && !pwdata[`ADCC_S_DONE]) begin
			next_s.done_flag = 1'b0;
		end

		// conversion sequencer
		next_s.tad_restart = 1'b0;
		case (s.phase)
			ADCC_IDLE: begin
				if (start_req) begin
					next_s.phase = ADCC_CONVERT;
					next_s.tad_count = 4'h0;
					next_s.tad_restart = 1'b1;
				end
			end
			ADCC_CONVERT: begin
				if (complete) begin
					next_s.phase = ADCC_HOLDOFF;
					next_s.tad_count = 4'h0;
					next_s.result = justify_code(s.justify, s.cmp_sync);
					next_s.done_flag = 1'b1;
				end else if (abort_req) begin
					next_s.phase = ADCC_HOLDOFF;
					next_s.tad_count = 4'h0;
					next_s.tad_restart = 1'b1;
				end else if (tad_tick) begin
					next_s.tad_count = s.tad_count + 4'h1;
				end
			end
			ADCC_HOLDOFF: begin
				if (tad_tick) begin
					if (s.tad_count == HOLDOFF_TADS - 4'h1) begin
						next_s.phase = ADCC_IDLE;
						next_s.tad_count = 4'h0;
					end else begin
						next_s.tad_count = s.tad_count + 4'h1;
					end
				end
			end
			default: begin
				next_s.phase = ADCC_IDLE;
			end
		endcase

		// power off drops any conversion at once
		if (!next_s.power_on) begin
			next_s.phase = ADCC_IDLE;
			next_s.tad_count = 4'h0;
		end

		// analog side controls
		next_s.converter_enable = next_s.power_on;
		next_s.mux_select = next_s.channel;
		next_s.analog_pins = pin_map(next_s.pin_cfg);
		next_s.vref_pos_ext = pos_ref(next_s.pin_cfg);
		next_s.vref_neg_ext = neg_ref(next_s.pin_cfg);
		next_s.sample_connect = next_s.power_on & (next_s.phase == ADCC_IDLE);
		next_s.convert_active = (next_s.phase == ADCC_CONVERT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.analog_pins <= 5'b11111;
		end else if (pclk_en) begin
			s <= next_s;
		end
	end
endmodule : adcc_conv_ctrl

/* File: design/adcc_tad_gen.sv */
// bit period generator: one-cycle tick per conversion bit period
// assumes pclk is the oscillator and rc_tick is already synchronised
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_tad_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	adcc_tad_if.gen bus
);
	import adcc_pkg::*;

	adcc_tad_state_t s;
	adcc_tad_state_t next_s;

	// ratio 2,4,8,16,32,64 from {select, halving}
	function automatic logic [6:0] tad_ratio(input logic [1:0] sel, input logic halve);
		tad_ratio = 7'h02 << {sel, halve};
	endfunction : tad_ratio

	assign bus.tick = s.tick;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (bus.restart || !bus.run) begin
			next_s.count = 6'h00;
		end else if (bus.clk_select == `ADCC_CLK_SEL_RC) begin
			next_s.count = 6'h00;
			next_s.tick = bus.rc_tick;
		end else if ({1'b0, s.count} == tad_ratio(bus.clk_select, bus.halving) - 7'h01) begin
			next_s.count = 6'h00;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (pclk_en) begin
			s <= next_s;
		end
	end
endmodule : adcc_tad_gen

/* File: pkg/adcc_pkg.sv */
// types shared by the converter control block
// assumes adcc_regs.svh supplies the numeric constants
package adcc_pkg;

	typedef enum logic [1:0] {
		ADCC_IDLE,
		ADCC_CONVERT,
		ADCC_HOLDOFF
	} adcc_phase_t;

	typedef struct packed {
		logic [5:0] count;
		logic tick;
	} adcc_tad_state_t;

	typedef struct packed {
		adcc_phase_t phase;
		logic [3:0] tad_count;
		logic tad_restart;
		logic [1:0] clk_select;
		logic [2:0] channel;
		logic power_on;
		logic justify;
		logic halving;
		logic [3:0] pin_cfg;
		logic [15:0] result;
		logic done_flag;
		logic rc_meta;
		logic rc_sync;
		logic rc_prev;
		logic [9:0] cmp_meta;
		logic [9:0] cmp_sync;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic converter_enable;
		logic [2:0] mux_select;
		logic [4:0] analog_pins;
		logic vref_pos_ext;
		logic vref_neg_ext;
		logic sample_connect;
		logic convert_active;
	} adcc_state_t;

endpackage : adcc_pkg

/* File: pkg/adcc_regs.svh */
// register indices, field positions, reset values and timing counts of the converter control block
// assumes an apb slave with 32-bit data where each register sits at four times its index
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_IDX_RESULT_HIGH 8'h1E
`define ADCC_IDX_CONTROL_A 8'h1F
`define ADCC_IDX_RESULT_LOW 8'h9E
`define ADCC_IDX_CONTROL_B 8'h9F
`define ADCC_IDX_STATUS 8'h20

`define ADCC_A_CLK_SEL_HI 7
`define ADCC_A_CLK_SEL_LO 6
`define ADCC_A_CHAN_HI 5
`define ADCC_A_CHAN_LO 3
`define ADCC_A_GO 2
`define ADCC_A_POWER 0

`define ADCC_B_JUSTIFY 7
`define ADCC_B_HALVING 6
`define ADCC_B_PCFG_HI 3
`define ADCC_B_PCFG_LO 0

`define ADCC_S_DONE 0

`define ADCC_RESET_CONTROL_A 8'h00
`define ADCC_RESET_CONTROL_B 8'h00

`define ADCC_CLK_SEL_RC 2'h3
`define ADCC_CONV_TADS 4'h9
`define ADCC_HOLDOFF_TADS 4'h2
`define ADCC_RESULT_BITS 10

`endif

/* File: pkg/adcc_tad_if.sv */
// link between the sequencer and its bit period generator
// assumes both ends run on pclk
`timescale 1ns/1ps
interface adcc_tad_if;
	logic [1:0] clk_select;
	logic halving;
	logic run;
	logic restart;
	logic rc_tick;
	logic tick;

	modport gen (
		input clk_select,
		input halving,
		input run,
		input restart,
		input rc_tick,
		output tick
	);

	modport ctl (
		output clk_select,
		output halving,
		output run,
		output restart,
		output rc_tick,
		input tick
	);
endinterface : adcc_tad_if

/* File: testbench/adcc_conv_ctrl_monitor.sv */
// port checker for the converter control block
// assumes a bind into adcc_conv_ctrl, one pclk domain, presetn low resets
`timescale 1ns/1ps
module adcc_conv_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic special_event_trigger,
	input wire logic converter_enable,
	input wire logic [4:0] analog_pins,
	input wire logic vref_pos_ext,
	input wire logic vref_neg_ext,
	input wire logic sample_connect,
	input wire logic convert_active,
	input wire logic conversion_done_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_off_idle: assert property (!converter_enable |-> !convert_active)
		else $error("converting while powered off");
	a_start_cause: assert property ($rose(convert_active) |-> converter_enable &&
		($past(special_event_trigger || (psel && pwrite && pready)) ||
		$past(special_event_trigger || (psel && pwrite && pready), 2)))
		else $error("conversion started without a request");
	a_conv_min: assert property ($rose(convert_active) |-> convert_active [*8])
		else $error("conversion too short");
	a_conn_off: assert property (convert_active |-> !sample_connect)
		else $error("sampler connected while converting");
	a_holdoff_gap: assert property ($fell(convert_active) |-> !sample_connect [*2])
		else $error("sampler reconnected without holdoff");
	a_done_rise: assert property ($rose(conversion_done_flag) |-> $fell(convert_active))
		else $error("done flag set outside completion");
	a_vref_neg: assert property (vref_neg_ext |-> vref_pos_ext && analog_pins[3:2] == 2'b11)
		else $error("negative reference without positive");
	a_rails_digital: assert property (analog_pins == 5'h00 |-> !vref_pos_ext)
		else $error("reference used with all pins digital");
	a_zero_a: assert property (pready && !pwrite && paddr == 12'h07c |-> prdata[1] == 1'b0)
		else $error("unimplemented bit of control a set");
	a_zero_b: assert property (pready && !pwrite && paddr == 12'h27c |-> prdata[5:4] == 2'b00)
		else $error("unimplemented bits of control b set");
	c_start: cover property ($rose(convert_active));
	c_done: cover property ($rose(conversion_done_flag));
	c_abort: cover property ($fell(convert_active) && !conversion_done_flag);
endmodule : adcc_conv_ctrl_monitor

/* File: testbench/adcc_conv_ctrl_tb.sv */
// self-checking bench for the converter control block
// assumes the front end model and the port checker beside the design
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_conv_ctrl_tb;
	localparam logic [7:0] CA = `ADCC_IDX_CONTROL_A;
	localparam logic [7:0] CB = `ADCC_IDX_CONTROL_B;
	localparam logic [7:0] RH = `ADCC_IDX_RESULT_HIGH;
	localparam logic [7:0] RL = `ADCC_IDX_RESULT_LOW;
	localparam logic [7:0] ST = `ADCC_IDX_STATUS;
	logic pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic special_event_trigger = 0, pready, pslverr, serr, rc_clock_pin;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic [9:0] cmp_code;
	logic [2:0] mux_select;
	logic [4:0] analog_pins;
	logic converter_enable, vref_pos_ext, vref_neg_ext, sample_connect, convert_active, conversion_done_flag;
	logic [7:0] last_h, last_l;
	int err_count = 0, cmp_count = 0, n;
	logic [6:0] pin_tab [16] = '{7'h7c, 7'h7e, 7'h7c, 7'h7e, 7'h2c, 7'h2e, 7'h00, 7'h00,
		7'h7f, 7'h7c, 7'h7e, 7'h7f, 7'h7f, 7'h3f, 7'h04, 7'h37};
	adcc_conv_ctrl dut (.*);
	adcc_front_model fe (.*);
	always #50 pclk = ~pclk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) err_count++;
		q = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rd(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		check(q, {24'h00_0000, e});
	endtask : rd
	task wait_for(input logic want, input logic which);
		time t0;
		t0 = $time;
		while ((which ? sample_connect : convert_active) !== want && $time - t0 < 80000) @(posedge pclk);
		if ($time - t0 >= 80000) err_count++;
		n = ($time - t0) / 100;
	endtask : wait_for
	task conv(input logic [7:0] a, input int tad, input logic [2:0] ch, input logic just);
		logic [9:0] code;
		time t0;
		code = {ch, ~ch, 4'h6};
		apb(1'b1, CA, a | 8'h04);
		t0 = $time;
		rd(CA, a | 8'h04);
		wait_for(1'b0, 1'b0);
		n = ($time - t0) / 100;
		check(n >= 8 * tad + 2 && n <= 9 * tad + 5, 1);
		wait_for(1'b1, 1'b1);
		check(n >= tad - 1 && n <= 2 * tad + 4, 1);
		last_h = just ? {6'h00, code[9:8]} : code[9:2];
		last_l = just ? code[7:0] : {code[1:0], 6'h00};
		rd(CA, a);
		rd(RH, last_h);
		rd(RL, last_l);
		rd(ST, 8'h01);
		apb(1'b1, ST, 8'h00);
		rd(ST, 8'h00);
	endtask : conv
	task trig;
		@(posedge pclk);
		special_event_trigger <= 1;
		@(posedge pclk);
		special_event_trigger <= 0;
		repeat (3) @(posedge pclk);
	endtask : trig
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	initial begin
		#2_000_000;
		err_count++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(CA, 8'h00);
		rd(CB, 8'h00);
		check(analog_pins, 5'h1f);
		apb(1'b1, CB, 8'hff);
		rd(CB, 8'hcf);
		apb(1'b1, CA, 8'h26);
		rd(CA, 8'h20);
		check(convert_active, 0);
		apb(1'b0, 8'h01, 8'h00);
		check(serr, 1);
		check(q, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, CB, i[7:0]);
			@(posedge pclk);
			check({analog_pins, vref_pos_ext, vref_neg_ext}, pin_tab[i]);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, CB, {i[1], i[0], 6'h00});
			apb(1'b1, CA, {i[2:1] | {2{i[2] & i[1]}}, 3'(i % 5), 3'b001});
			@(posedge pclk);
			check({converter_enable, mux_select}, {1'b1, 3'(i % 5)});
			repeat (20) @(posedge pclk);
			conv({i[2:1] | {2{i[2] & i[1]}}, 3'(i % 5), 3'b001}, i > 5 ? 20 : 2 << i, 3'(i % 5), i[1]);
		end
		apb(1'b1, CB, 8'h40);
		apb(1'b1, CA, 8'h81);
		repeat (20) @(posedge pclk);
		apb(1'b1, CA, 8'h85);
		repeat (100) @(posedge pclk);
		apb(1'b1, CA, 8'h81);
		wait_for(1'b1, 1'b1);
		rd(RH, last_h);
		rd(RL, last_l);
		rd(ST, 8'h00);
		apb(1'b1, CA, 8'h00);
		trig;
		check({converter_enable, convert_active}, 0);
		apb(1'b1, CA, 8'h01);
		repeat (20) @(posedge pclk);
		trig;
		check(convert_active, 1);
		wait_for(1'b1, 1'b1);
		rd(ST, 8'h01);
		give_verdict;
	end
endmodule : adcc_conv_ctrl_tb
bind adcc_conv_ctrl adcc_conv_ctrl_monitor mon (.*);

/* File: testbench/adcc_front_model.sv */
// analog front end model: internal rc oscillator and comparator code
// assumes the code is taken only while the converter is powered
`timescale 1ns/1ps
module adcc_front_model #(
	parameter int RC_HALF_NS = 1000
) (
	input wire logic pclk,
	input wire logic converter_enable,
	input wire logic [2:0] mux_select,
	output logic rc_clock_pin,
	output logic [9:0] cmp_code
);
	logic [9:0] junk = 10'h155;
	initial rc_clock_pin = 1'b0;
	// oscillator stands still while the converter is off
	always #(RC_HALF_NS) rc_clock_pin = converter_enable ? ~rc_clock_pin : 1'b0;
	always @(posedge pclk) junk <= ~junk;
	assign cmp_code = converter_enable ? {mux_select, ~mux_select, 4'h6} : junk;
endmodule : adcc_front_model
